/* File: core/dcf_pkg.sv */
// shared constants for the code-format and reset front end
package dcf_pkg;
    // code width and fixed code values
    localparam int unsigned DCF_CODE_W     = 16;
    localparam logic [15:0] DCF_ZERO_SCALE = 16'h0000;
    localparam logic [15:0] DCF_MID_SCALE  = 16'h8000;
    localparam logic [15:0] DCF_MSB_FLIP   = 16'h8000;
    localparam int unsigned DCF_FIFO_DEPTH = 16;

    // strap and pin positions in the synchronised pin vector
    localparam int unsigned DCF_PIN_W      = 8;
    localparam int unsigned DCF_PIN_SCLK   = 7;
    localparam int unsigned DCF_PIN_CS_N   = 6;
    localparam int unsigned DCF_PIN_DIN    = 5;
    localparam int unsigned DCF_PIN_RST_N  = 4;
    localparam int unsigned DCF_PIN_LOAD_N = 3;
    localparam int unsigned DCF_PIN_FMT    = 2;
    localparam int unsigned DCF_PIN_GAIN   = 1;
    localparam int unsigned DCF_PIN_RSEL   = 0;

    // last settle count after reset release; the synchronised pins are trusted one cycle after it is reached
    localparam logic [1:0]  DCF_SETTLE     = 2'h3;

    // register byte offsets
    localparam logic [7:0]  DCF_ADDR_CTRL  = 8'h00;
    localparam logic [7:0]  DCF_ADDR_STAT  = 8'h04;
    localparam logic [7:0]  DCF_ADDR_INREG = 8'h08;
    localparam logic [7:0]  DCF_ADDR_LATCH = 8'h0C;
    localparam logic [7:0]  DCF_ADDR_DROP  = 8'h10;

    // control fields, reset value all zero
    localparam int unsigned DCF_CTRL_HOLD  = 0;
    localparam int unsigned DCF_CTRL_PAUSE = 1;

    // status fields
    localparam int unsigned DCF_ST_RESET   = 0;
    localparam int unsigned DCF_ST_EMPTY   = 1;
    localparam int unsigned DCF_ST_FULL    = 2;
    localparam int unsigned DCF_ST_FMT     = 3;
    localparam int unsigned DCF_ST_GAIN    = 4;
    localparam int unsigned DCF_ST_RSEL    = 5;
    localparam int unsigned DCF_ST_LEVEL   = 8;

    // bus encodings
    localparam logic        DCF_HRESP_OKAY = 1'b0;
endpackage

/* File: core/dcf_top.sv */
// code-format, reset-level and double-buffer front end with its word fifo
//
// Summary of operation
// - each code arrives as one 16-bit word over the serial link from the host
// - after power-up both registers take zero or midscale per reset-level select
// - format select high means codes are unsigned straight binary
// - format select low means codes are signed twos complement
// - binary FFFF is full scale minus one, 8000 midscale, 0000 zero
// - twos 7FFF full minus one, 0000 midscale, FFFF just below, 8000 zero
// - converter code 0..65535 sets output in steps of span/65536 times gain
// - gain select low gives gain one, high gives gain two
// - while the reset pin is low both registers hold the reset value
// - after the reset pin rises, normal operation and serial writes resume
// - reset value is 0000 with reset-level select low, 8000 when high
// - latch-load low makes the latch follow the input register, high holds it
// - a frame shorter than 16 bits is dropped, registers keep old values
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps

module dcf_fifo
    import dcf_pkg::*;
#(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       flush,
    // filling side
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    // draining side
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic [$clog2(DEPTH):0]          level
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    // pointers wrap by plain overflow, so depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
        $error("dcf_fifo: DEPTH must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } dcf_fifo_state_t;

    dcf_fifo_state_t st_ff;
    dcf_fifo_state_t nxt_st;
    logic            push;
    logic            pop;

    // honest flags straight from the count
    assign in_ready  = (st_ff.cnt != FULL_CNT);
    assign out_valid = (st_ff.cnt != '0);
    assign out_data  = st_ff.mem[st_ff.rp];
    assign level     = st_ff.cnt;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // next state: flush wins over traffic
    always_comb begin
        nxt_st = st_ff;
        if (flush) begin
            nxt_st.wp  = '0;
            nxt_st.rp  = '0;
            nxt_st.cnt = '0;
        end else begin
            if (push) begin
                nxt_st.mem[st_ff.wp] = in_data;
                nxt_st.wp            = st_ff.wp + 1'b1;
            end
            if (pop) begin
                nxt_st.rp = st_ff.rp + 1'b1;
            end
            if (push && !pop) begin
                nxt_st.cnt = st_ff.cnt + 1'b1;
            end else if (pop && !push) begin
                nxt_st.cnt = st_ff.cnt - 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

module dcf_top
    import dcf_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = DCF_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // serial link from the host
    input  wire logic        spi_sclk,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_din,
    // reset and load pins, straps
    input  wire logic        hw_reset_n,
    input  wire logic        latch_load_strobe_n,
    input  wire logic        code_format_select,
    input  wire logic        gain_select,
    input  wire logic        reset_level_select,
    // converter side
    output logic [15:0]      conv_code,
    output logic [16:0]      out_steps,
    output logic             gain_x2,
    output logic             in_reset
);
    localparam int unsigned LVL_W = $clog2(FIFO_DEPTH) + 1;

    // status field must fit beside the flags
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128) begin : g_bad
        $error("dcf_top: FIFO_DEPTH must lie in 2..128");
    end

    typedef struct packed {
        logic [DCF_PIN_W-1:0] pin_meta;
        logic [DCF_PIN_W-1:0] pin_sync;
        logic                 sclk_prev;
        logic                 cs_act_prev;
        logic [1:0]           settle;
        logic                 por_done;
        logic [15:0]          shift;
        logic [4:0]           bits;
        logic [15:0]          in_reg;
        logic [15:0]          latch;
        logic [16:0]          steps;
        logic                 gain;
        logic                 ctrl_hold;
        logic                 ctrl_pause;
        logic                 wr_pend;
        logic [7:0]           dp_addr;
        logic [31:0]          rdata;
        logic [15:0]          short_cnt;
        logic [15:0]          ovf_cnt;
    } dcf_state_t;

    dcf_state_t       st_ff;
    dcf_state_t       nxt_st;
    logic [DCF_PIN_W-1:0] pins;
    logic             sclk_s;
    logic             cs_act;
    logic             sclk_rise;
    logic             frame_end;
    logic             fmt_binary;
    logic [15:0]      rst_val;
    logic             push_valid;
    logic [15:0]      push_data;
    logic             push_ready;
    logic             pop_valid;
    logic             pop_ready;
    logic [15:0]      pop_data;
    logic [LVL_W-1:0] fifo_level;
    logic             acc;

    // gather every pin that crosses into hclk
    assign pins = {spi_sclk, spi_cs_n, spi_din, hw_reset_n,
                   latch_load_strobe_n, code_format_select,
                   gain_select, reset_level_select};

    // only the second sync stage is decoded
    assign sclk_s     = st_ff.pin_sync[DCF_PIN_SCLK];
    assign cs_act     = ~st_ff.pin_sync[DCF_PIN_CS_N];
    assign sclk_rise  = sclk_s & ~st_ff.sclk_prev;
    assign frame_end  = ~cs_act & st_ff.cs_act_prev;
    assign fmt_binary = st_ff.pin_sync[DCF_PIN_FMT];

    // reset covers power-up settle, the pin and the software hold
    assign in_reset = ~st_ff.por_done | ~st_ff.pin_sync[DCF_PIN_RST_N] | st_ff.ctrl_hold;
    assign rst_val  = st_ff.pin_sync[DCF_PIN_RSEL] ? DCF_MID_SCALE : DCF_ZERO_SCALE;

    // a full frame is at least 16 rising edges; extra bits keep the last 16
    assign push_valid = frame_end & (st_ff.bits == 5'(DCF_CODE_W)) & ~in_reset;
    assign push_data  = fmt_binary ? st_ff.shift : (st_ff.shift ^ DCF_MSB_FLIP);
    assign pop_ready  = ~st_ff.ctrl_pause & ~in_reset;

    assign acc       = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = DCF_HRESP_OKAY;
    assign hrdata    = st_ff.rdata;
    assign conv_code = st_ff.latch;
    assign out_steps = st_ff.steps;
    assign gain_x2   = st_ff.gain;

    // read mux; reads see writes of the cycle before
    function automatic logic [31:0] rd_word(input logic [7:0] a, input dcf_state_t s,
                                            input logic rs, input logic [LVL_W-1:0] lv,
                                            input logic em, input logic fu);
        logic [31:0] w;
        w = '0;
        if (a == DCF_ADDR_CTRL) begin
            w[DCF_CTRL_HOLD]  = s.ctrl_hold;
            w[DCF_CTRL_PAUSE] = s.ctrl_pause;
        end else if (a == DCF_ADDR_STAT) begin
            w[DCF_ST_RESET]          = rs;
            w[DCF_ST_EMPTY]          = em;
            w[DCF_ST_FULL]           = fu;
            w[DCF_ST_FMT]            = s.pin_sync[DCF_PIN_FMT];
            w[DCF_ST_GAIN]           = s.pin_sync[DCF_PIN_GAIN];
            w[DCF_ST_RSEL]           = s.pin_sync[DCF_PIN_RSEL];
            w[DCF_ST_LEVEL +: LVL_W] = lv;
        end else if (a == DCF_ADDR_INREG) begin
            w[15:0] = s.in_reg;
        end else if (a == DCF_ADDR_LATCH) begin
            w[15:0] = s.latch;
        end else if (a == DCF_ADDR_DROP) begin
            w = {s.ovf_cnt, s.short_cnt};
        end
        return w;
    endfunction

    // words wait here so a paused drain cannot lose host frames silently
    dcf_fifo #(
        .WIDTH (DCF_CODE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (hclk),
        .rst_n     (hresetn),
        .flush     (in_reset),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_data),
        .level     (fifo_level)
    );

    // next state of the whole block
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.pin_meta = pins;
        nxt_st.pin_sync = st_ff.pin_meta;
        nxt_st.sclk_prev   = sclk_s;
        nxt_st.cs_act_prev = cs_act;
        // straps are trusted only once both sync stages hold real levels
        if (st_ff.settle != DCF_SETTLE) begin
            nxt_st.settle = st_ff.settle + 2'h1;
        end else begin
            nxt_st.por_done = 1'b1;
        end
        // serial shift; edges outside a frame are ignored
        if (!cs_act) begin
            nxt_st.bits = '0;
        end else if (sclk_rise) begin
            nxt_st.shift = {st_ff.shift[14:0], st_ff.pin_sync[DCF_PIN_DIN]};
            if (st_ff.bits != 5'(DCF_CODE_W)) begin
                nxt_st.bits = st_ff.bits + 5'h01;
            end
        end
        // short and overflowing frames are counted outside reset; frames ending in reset are dropped uncounted
        if (frame_end && !in_reset && st_ff.bits != 5'(DCF_CODE_W)) begin
            nxt_st.short_cnt = st_ff.short_cnt + 16'h0001;
        end
        if (push_valid && !push_ready) begin
            nxt_st.ovf_cnt = st_ff.ovf_cnt + 16'h0001;
        end
        // input register: reset value, else the next word from the fifo
        if (in_reset) begin
            nxt_st.in_reg = rst_val;
            nxt_st.latch  = rst_val;
        end else begin
            if (pop_valid && pop_ready) begin
                nxt_st.in_reg = pop_data;
            end
            // latch is transparent while the load pin is low
            if (!st_ff.pin_sync[DCF_PIN_LOAD_N]) begin
                nxt_st.latch = st_ff.in_reg;
            end
        end
        // output step count: code times buffer gain
        nxt_st.gain  = st_ff.pin_sync[DCF_PIN_GAIN];
        nxt_st.steps = st_ff.pin_sync[DCF_PIN_GAIN] ? {st_ff.latch, 1'b0}
                                                    : {1'b0, st_ff.latch};
        // bus data phase write, then capture of the next address phase
        if (st_ff.wr_pend && st_ff.dp_addr == DCF_ADDR_CTRL) begin
            nxt_st.ctrl_hold  = hwdata[DCF_CTRL_HOLD];
            nxt_st.ctrl_pause = hwdata[DCF_CTRL_PAUSE];
        end
        nxt_st.wr_pend = acc & hwrite;
        if (acc) begin
            nxt_st.dp_addr = haddr[7:0];
        end
        if (acc && !hwrite) begin
            nxt_st.rdata = rd_word(haddr[7:0], nxt_st, in_reset, fifo_level,
                                   ~pop_valid, ~push_ready);
        end
    end

    // state register; async reset loads constants only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_reset_value_load: assert property (in_reset |=> st_ff.in_reg == $past(rst_val)
                                         && st_ff.latch == $past(rst_val))
        else $error("reset value not loaded");
    a_reset_level_map: assert property (in_reset && st_ff.pin_sync[DCF_PIN_RSEL]
                                        |=> st_ff.latch == 16'h8000)
        else $error("midscale reset value wrong");
    a_power_up_hold: assert property (!st_ff.por_done |-> in_reset)
        else $error("power-up not held in reset");
    a_latch_follows: assert property (!in_reset && !st_ff.pin_sync[DCF_PIN_LOAD_N] && !$past(in_reset)
                                      |=> st_ff.latch == $past(st_ff.in_reg))
        else $error("latch did not follow input register");
    a_latch_holds: assert property (!in_reset && st_ff.pin_sync[DCF_PIN_LOAD_N]
                                    |=> $stable(st_ff.latch))
        else $error("latch changed while load pin high");
    a_short_dropped: assert property (frame_end && st_ff.bits < 5'h10
                                      |-> !push_valid ##1 $stable(st_ff.ovf_cnt))
        else $error("short frame reached the fifo");
    a_twos_msb_flip: assert property (push_valid && !fmt_binary
                                      |-> push_data == {~st_ff.shift[15], st_ff.shift[14:0]})
        else $error("twos code msb not inverted");
    a_binary_pass: assert property (push_valid && fmt_binary |-> push_data == st_ff.shift)
        else $error("binary code altered");
    a_gain_steps: assert property (##1 st_ff.steps == (st_ff.gain ? {$past(st_ff.latch), 1'b0}
                                                                  : {1'b0, $past(st_ff.latch)}))
        else $error("output steps do not match code and gain");
    a_resume_write: assert property (!in_reset && pop_valid && pop_ready
                                     |=> st_ff.in_reg == $past(pop_data))
        else $error("word not taken after reset");
    a_bus_okay: assert property (hreadyout && hresp == DCF_HRESP_OKAY)
        else $error("bus answer not ready okay");

    c_short_frame: cover property (frame_end && !in_reset && st_ff.bits < 5'h10);
    c_fifo_full:   cover property (push_valid && !push_ready);
    c_twos_word:   cover property (push_valid && !fmt_binary ##[1:40] st_ff.latch == $past(push_data, 2));
    c_reset_exit:  cover property ($fell(in_reset) ##[1:200] pop_valid && pop_ready);
endmodule

/* File: test/dcf_spi_host.sv */
// serial host model that drives code frames into the front end
`timescale 1ns/100ps

module dcf_spi_host (
    // clock
    input  wire logic hclk,
    // serial pins
    output logic      sclk,
    output logic      cs_n,
    output logic      din
);
    // idle pins: frame select high, serial clock parked low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // one frame of n bits, msb first; fewer than 16 bits makes a frame the device must drop
    task automatic send(input logic [15:0] w, input int n);
        @(posedge hclk);
        cs_n <= 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            repeat (2) @(posedge hclk);
            din  <= w[i];
            repeat (3) @(posedge hclk);
            sclk <= 1'b1;
            repeat (3) @(posedge hclk);
            sclk <= 1'b0;
        end
        repeat (3) @(posedge hclk);
        cs_n <= 1'b1;
        // released data line must not keep showing the last bit
        din  <= ~din;
        repeat (4) @(posedge hclk);
    endtask
endmodule

/* File: test/dcf_top_bench.sv */
// self-checking bench for the code-format and reset front end
`timescale 1ns/100ps

module dcf_top_bench
    import dcf_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        spi_sclk;
    logic        spi_cs_n;
    logic        spi_din;
    logic        hw_reset_n;
    logic        load_n;
    logic        fmt;
    logic        gain;
    logic        rsel;
    logic [15:0] conv_code;
    logic [16:0] out_steps;
    logic        gain_x2;
    logic        in_reset;
    logic [31:0] rd;
    int          failures;
    int          checks;
    int          cycles;

    dcf_top #(.FIFO_DEPTH(DCF_FIFO_DEPTH)) u_dcf_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_din(spi_din), .hw_reset_n(hw_reset_n),
        .latch_load_strobe_n(load_n), .code_format_select(fmt), .gain_select(gain),
        .reset_level_select(rsel), .conv_code(conv_code), .out_steps(out_steps),
        .gain_x2(gain_x2), .in_reset(in_reset));

    dcf_spi_host u_dcf_spi_host (.hclk(hclk), .sclk(spi_sclk), .cs_n(spi_cs_n), .din(spi_din));

    // clock, 10 ns period
    always #5 hclk = ~hclk;

    // hang guard: runs well above the longest expected sequence
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            failures++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // single-word write; zero-wait slave, but the wait on hready is kept
    task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic ahb_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= 1'b0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
        chk({31'h0, hresp}, {31'h0, DCF_HRESP_OKAY});
    endtask

    // wait bounded for the latch, then check it and the scaled output two cycles on
    task automatic wait_code(input logic [15:0] exp);
        for (int i = 0; i < 40 && conv_code !== exp; i++) @(posedge hclk);
        chk({16'h0, conv_code}, {16'h0, exp});
        repeat (2) @(posedge hclk);
        chk({15'h0, out_steps}, gain ? {15'h0, exp, 1'b0} : {16'h0, exp});
    endtask

    task automatic complete_run();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // binary and twos code tables: sent word and expected converter code
    logic [15:0] bin_w [4] = '{16'hFFFF, 16'h8000, 16'h0000, 16'hC000};
    logic [15:0] twos_w[5] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000, 16'h4000};
    logic [15:0] twos_e[5] = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000, 16'hC000};

    initial begin
        hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
        hsize = 3'h2; hwdata = 0; hw_reset_n = 1; load_n = 0; fmt = 1; gain = 0; rsel = 1;
        failures = 0; checks = 0; cycles = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (10) @(posedge hclk);
        chk({16'h0, conv_code}, {16'h0, DCF_MID_SCALE});
        ahb_read(DCF_ADDR_INREG, rd);
        chk(rd, 32'h00008000);
        chk({31'h0, in_reset}, 32'h0);
        $display("power-up reset done");

        // straight binary, then gain two on the last code
        foreach (bin_w[i]) begin
            if (i == 3) gain <= 1'b1;
            u_dcf_spi_host.send(bin_w[i], 16);
            wait_code(bin_w[i]);
        end
        chk({31'h0, gain_x2}, 32'h1);
        gain <= 1'b0;
        $display("binary format done");

        // twos complement: msb inverted on the way in
        fmt <= 1'b0;
        repeat (6) @(posedge hclk);
        foreach (twos_w[i]) begin
            u_dcf_spi_host.send(twos_w[i], 16);
            wait_code(twos_e[i]);
        end
        $display("twos format done");

        // latch holds while load is high, follows once it drops
        load_n <= 1'b1;
        u_dcf_spi_host.send(16'h1234, 16);
        repeat (10) @(posedge hclk);
        ahb_read(DCF_ADDR_INREG, rd);
        chk(rd, 32'h00009234);
        chk({16'h0, conv_code}, 32'h0000C000);
        load_n <= 1'b0;
        wait_code(16'h9234);
        // short frame is dropped and counted
        u_dcf_spi_host.send(16'hABCD, 12);
        repeat (10) @(posedge hclk);
        chk({16'h0, conv_code}, 32'h00009234);
        ahb_read(DCF_ADDR_DROP, rd);
        chk(rd, 32'h00000001);
        $display("load and short frame done");

        // hardware reset to zero-scale; load kept high in twos mode until a word lands
        load_n <= 1'b1;
        rsel <= 1'b0;
        hw_reset_n <= 1'b0;
        repeat (8) @(posedge hclk);
        chk({16'h0, conv_code}, {16'h0, DCF_ZERO_SCALE});
        chk({31'h0, in_reset}, 32'h1);
        u_dcf_spi_host.send(16'h5555, 16);
        chk({16'h0, conv_code}, 32'h0);
        hw_reset_n <= 1'b1;
        repeat (8) @(posedge hclk);
        chk({31'h0, in_reset}, 32'h0);
        u_dcf_spi_host.send(16'h0123, 16);
        load_n <= 1'b0;
        wait_code(16'h8123);
        $display("hardware reset done");

        // stall the drain, fill the buffer past full, then drain it
        ahb_write(DCF_ADDR_CTRL, 32'h00000002);
        ahb_read(DCF_ADDR_CTRL, rd);
        chk(rd, 32'h00000002);
        for (int i = 0; i <= DCF_FIFO_DEPTH; i++) u_dcf_spi_host.send(16'h0100 + 16'(i), 16);
        ahb_read(DCF_ADDR_STAT, rd);
        chk({20'h0, rd[12:8], 5'h0, rd[2:1]}, {20'h0, 5'(DCF_FIFO_DEPTH), 5'h0, 2'h2});
        ahb_read(DCF_ADDR_DROP, rd);
        chk(rd, 32'h00010001);
        chk({16'h0, conv_code}, 32'h00008123);
        ahb_write(DCF_ADDR_CTRL, 32'h00000000);
        wait_code(16'h8100 + 16'(DCF_FIFO_DEPTH - 1));
        ahb_read(DCF_ADDR_STAT, rd);
        chk({30'h0, rd[2:1]}, 32'h1);
        ahb_write(8'h20, 32'hFFFFFFFF);
        ahb_read(8'h20, rd);
        chk(rd, 32'h0);
        $display("buffer and unmapped access done");
        complete_run();
    end
endmodule
